// ### adcctl_consts.vh
`ifndef ADCCTL_CONSTS_VH
`define ADCCTL_CONSTS_VH
// register byte addresses (word aligned on the bus: offset & ~3)
`define ADCCTL_OFS_RES_LOW 8'h78
`define ADCCTL_OFS_RES_HIGH 8'h79
`define ADCCTL_OFS_CTRL_STAT 8'h7a
`define ADCCTL_OFS_TRIG_CFG 8'h7b
`define ADCCTL_OFS_INPUT_SEL 8'h7c
// word indices of the registers (byte address / 4 gives word)
`define ADCCTL_IDX_RES 6'h1e
`define ADCCTL_IDX_CFG 6'h1f
// control/status bit positions
`define ADCCTL_BIT_ENABLE 7
`define ADCCTL_BIT_START 6
`define ADCCTL_BIT_AUTO 5
`define ADCCTL_BIT_FLAG 4
`define ADCCTL_BIT_IRQ_EN 3
// input select fields
`define ADCCTL_BIT_LEFT 5
`define ADCCTL_REF_EXT_PIN 2'h0
`define ADCCTL_REF_SUPPLY 2'h1
`define ADCCTL_REF_RESERVED 2'h2
`define ADCCTL_REF_INTERNAL 2'h3
`define ADCCTL_CH_LAST_EXT 5'h07
`define ADCCTL_CH_BANDGAP 5'h1e
`define ADCCTL_CH_GROUND 5'h1f
// conversion lengths in converter clocks
`define ADCCTL_FIRST_CYCLES 5'h19
`define ADCCTL_NORMAL_CYCLES 5'h0d
// code limits
`define ADCCTL_CODE_MIN 10'h000
`define ADCCTL_CODE_MAX 10'h3ff
// trigger source free running
`define ADCCTL_TRIG_FREE 3'h0
`define ADCCTL_RESET_BYTE 8'h00
`endif

// ### adcctl_top.v
`timescale 1ns/1ps
`include "adcctl_consts.vh"

module adcctl_top (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // avalon-mm slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // analog front end
  output reg [1:0] REFERENCE_SELECT,
  output reg [4:0] CHANNEL_SELECT,
  output reg ANALOG_POWER_ON,
  output reg SAMPLE_HOLD,
  input wire [9:0] CONVERSION_CODE,
  // trigger inputs, one per trigger source code
  input wire [7:0] TRIGGER_SOURCES,
  // processor interrupt hookup
  input wire GLOBAL_IRQ_ENABLE,
  input wire IRQ_VECTOR_TAKEN,
  output reg COMPLETION_IRQ
);

  // reset release
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // prescaler half-period length from divider code
  function [6:0] half_div;
    input [2:0] sel;
    begin
      case (sel)
        3'h0, 3'h1: half_div = 7'h01;
        3'h2: half_div = 7'h02;
        3'h3: half_div = 7'h04;
        3'h4: half_div = 7'h08;
        3'h5: half_div = 7'h10;
        3'h6: half_div = 7'h20;
        default: half_div = 7'h40;
      endcase
    end
  endfunction

  // result layout per justification
  function [15:0] layout;
    input [9:0] code;
    input left;
    begin
      if (left)
        layout = {code, 6'h00};
      else
        layout = {6'h00, code};
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [7:0] input_sel_reg;
  reg [7:0] ctrl_reg; // enable, auto, irq enable, divider (start/flag separate)
  reg [2:0] trig_sel_reg;
  reg start_reg;
  reg flag_reg;
  reg [1:0] state_reg;
  reg [4:0] cyc_reg;
  reg [4:0] cyc_len_reg;
  reg first_reg;
  reg [9:0] result_reg;
  reg locked_reg;
  reg [6:0] pre_cnt_reg;
  reg adc_clk_reg;
  reg trig_prev_reg;

  wire enable = ctrl_reg[`ADCCTL_BIT_ENABLE];
  wire auto = ctrl_reg[`ADCCTL_BIT_AUTO];
  wire [2:0] div_sel = ctrl_reg[2:0];
  wire word_hit_res = (AVS_ADDRESS[7:2] == `ADCCTL_IDX_RES);
  wire word_hit_cfg = (AVS_ADDRESS[7:2] == `ADCCTL_IDX_CFG);
  wire do_wr = AVS_WRITE && !AVS_WAITREQUEST;
  wire do_rd = AVS_READ && !AVS_WAITREQUEST;
  // byte lanes: 0x78 lane0, 0x79 lane1, 0x7a lane2, 0x7b lane3, 0x7c lane0 of next word
  wire wr_ctrl = do_wr && word_hit_res && AVS_BYTEENABLE[2];
  wire wr_trig = do_wr && word_hit_res && AVS_BYTEENABLE[3];
  wire wr_insel = do_wr && word_hit_cfg && AVS_BYTEENABLE[0];
  wire rd_low = do_rd && word_hit_res && AVS_BYTEENABLE[0];
  wire rd_high = do_rd && word_hit_res && AVS_BYTEENABLE[1];
  wire [7:0] wctl = AVS_WRITEDATA[23:16];
  wire [15:0] shown = layout(result_reg, input_sel_reg[`ADCCTL_BIT_LEFT]);

  // converter clock tick, one per rising converter clock
  wire tick = (pre_cnt_reg == half_div(div_sel) - 7'h01) && !adc_clk_reg;
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg <= 7'h00;
      adc_clk_reg <= 1'b0;
    end
    else if (!enable)
    begin
      pre_cnt_reg <= 7'h00;
      adc_clk_reg <= 1'b0;
    end
    else if (pre_cnt_reg >= half_div(div_sel) - 7'h01)
    begin
      pre_cnt_reg <= 7'h00;
      adc_clk_reg <= ~adc_clk_reg;
    end
    else
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
  end

  // trigger edge, source 0 (free running) never yields an edge
  wire trig_now = (trig_sel_reg == `ADCCTL_TRIG_FREE) ? 1'b0 : TRIGGER_SOURCES[trig_sel_reg];
  wire trig_edge = trig_now && !trig_prev_reg;
  // enable as it stands after this edge, so a start written with the enable counts
  wire en_write = wr_ctrl && wctl[`ADCCTL_BIT_ENABLE];
  wire fresh_enable = en_write && !enable;
  wire sw_start = en_write && wctl[`ADCCTL_BIT_START];
  wire free_restart = (state_reg == ST_DONE) && auto && (trig_sel_reg == `ADCCTL_TRIG_FREE);
  wire go = sw_start || (enable && ((auto && trig_edge) || free_restart));
  wire finish = (state_reg == ST_CONV) && tick && (cyc_reg == cyc_len_reg - 5'h01);
  wire abort = wr_ctrl && !wctl[`ADCCTL_BIT_ENABLE];
  // a start only lands between conversions; a disable in the same cycle wins
  wire idle_like = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
  wire launch = go && idle_like && !abort;
  wire first_now = first_reg || fresh_enable;

  // software-written configuration; start and flag keep their own flops
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_sel_reg <= `ADCCTL_RESET_BYTE;
      ctrl_reg <= `ADCCTL_RESET_BYTE;
      trig_sel_reg <= 3'h0;
    end
    else
    begin
      if (wr_insel)
        input_sel_reg <= AVS_WRITEDATA[7:0];
      if (wr_trig)
        trig_sel_reg <= AVS_WRITEDATA[26:24];
      if (wr_ctrl)
        ctrl_reg <= {wctl[7], 1'b0, wctl[5], 1'b0, wctl[3:0]};
    end
  end

  // trigger history for edge detection
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_now;
  end

  // analog power follows the enable bit
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ANALOG_POWER_ON <= 1'b0;
    else
      ANALOG_POWER_ON <= wr_ctrl ? wctl[`ADCCTL_BIT_ENABLE] : enable;
  end

  // mux settings follow only between conversions, so a change waits for completion
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      REFERENCE_SELECT <= `ADCCTL_REF_EXT_PIN;
      CHANNEL_SELECT <= 5'h00;
    end
    else if (state_reg != ST_CONV)
    begin
      REFERENCE_SELECT <= input_sel_reg[7:6];
      CHANNEL_SELECT <= input_sel_reg[4:0];
    end
  end

  // first conversion after an enable runs the long initialisation length
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      first_reg <= 1'b1;
    else if (launch)
      first_reg <= 1'b0;
    else if (fresh_enable)
      first_reg <= 1'b1;
  end

  // busy bit: reads one while converting, software zero writes ignored
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      start_reg <= 1'b0;
    else if (abort)
      start_reg <= 1'b0;
    else if (launch)
      start_reg <= 1'b1;
    else if (finish)
      start_reg <= 1'b0;
  end

  // converter clock count inside a conversion
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      cyc_reg <= 5'h00;
    else if (launch)
      cyc_reg <= 5'h00;
    else if ((state_reg == ST_CONV) && tick)
      cyc_reg <= cyc_reg + 5'h01;
  end

  // conversion length, fixed when the conversion launches
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      cyc_len_reg <= `ADCCTL_NORMAL_CYCLES;
    else if (launch)
      cyc_len_reg <= first_now ? `ADCCTL_FIRST_CYCLES : `ADCCTL_NORMAL_CYCLES;
  end

  // conversion sequencer; a disable ends any conversion at once
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      SAMPLE_HOLD <= 1'b0;
    end
    else if (abort)
    begin
      state_reg <= ST_IDLE;
      SAMPLE_HOLD <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE, ST_DONE:
        begin
          state_reg <= ST_IDLE;
          if (launch)
          begin
            state_reg <= ST_CONV;
            SAMPLE_HOLD <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (finish)
          begin
            state_reg <= ST_DONE;
            SAMPLE_HOLD <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // result capture; low read locks, high read unlocks
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg <= `ADCCTL_CODE_MIN;
      locked_reg <= 1'b0;
    end
    else
    begin
      if (finish && !abort && !locked_reg)
        result_reg <= CONVERSION_CODE;
      if (rd_high)
        locked_reg <= 1'b0;
      else if (rd_low)
        locked_reg <= 1'b1;
    end
  end

  // completion flag: set wins over any clear in the same cycle
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else if (finish && !abort)
      flag_reg <= 1'b1;
    else if (IRQ_VECTOR_TAKEN || (wr_ctrl && wctl[`ADCCTL_BIT_FLAG]))
      flag_reg <= 1'b0;
  end

  // interrupt request, one cycle behind the flag
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      COMPLETION_IRQ <= 1'b0;
    else
      COMPLETION_IRQ <= flag_reg && ctrl_reg[`ADCCTL_BIT_IRQ_EN] && GLOBAL_IRQ_ENABLE;
  end

  // status and result word: trigger source, control byte, result bytes
  function [31:0] res_word;
    input [2:0] src;
    input [7:0] ctl;
    input busy;
    input done;
    input [15:0] res;
    begin
      res_word = {5'h00, src, ctl[7], busy, ctl[5], done, ctl[3:0], res};
    end
  endfunction

  // avalon wait state: one cycle high then low for each request
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
  end

  // read data captured while waitrequest is high, standing in the answer cycle
  always @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      AVS_READDATA <= 32'h0000_0000;
    else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST)
    begin
      if (word_hit_res)
        AVS_READDATA <= res_word(trig_sel_reg, ctrl_reg, start_reg, flag_reg, shown);
      else if (word_hit_cfg)
        AVS_READDATA <= {24'h000000, input_sel_reg};
      else
        AVS_READDATA <= 32'h0000_0000;
    end
  end

endmodule

// ### adcctl_properties.sv
`timescale 1ns/1ps
module adcctl_properties (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // register bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  input wire AVS_WAITREQUEST,
  // converter and interrupt side
  input wire [1:0] REFERENCE_SELECT,
  input wire [4:0] CHANNEL_SELECT,
  input wire ANALOG_POWER_ON,
  input wire SAMPLE_HOLD,
  input wire GLOBAL_IRQ_ENABLE,
  input wire IRQ_VECTOR_TAKEN,
  input wire COMPLETION_IRQ
);
  logic [11:0] hold_cnt;
  // cycles spent sampling in the current conversion
  always @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
      hold_cnt <= 12'h000;
    else
      hold_cnt <= SAMPLE_HOLD ? hold_cnt + 12'h001 : 12'h000;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // accepted write to the control lane
  sequence s_ctrl_wr;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[7:2] == 6'h1e && AVS_BYTEENABLE[2];
  endsequence
  // vector taken while no conversion can finish
  sequence s_vec_idle;
    IRQ_VECTOR_TAKEN && !SAMPLE_HOLD;
  endsequence
  a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest not low one cycle after request");
  a_enable_write: assert property (s_ctrl_wr |=> ANALOG_POWER_ON == $past(AVS_WRITEDATA[23]))
    else $error("power does not follow enable write");
  a_off_aborts: assert property ($fell(ANALOG_POWER_ON) |-> ##[0:2] !SAMPLE_HOLD)
    else $error("conversion survives disable");
  a_start_powered: assert property ($rose(SAMPLE_HOLD) |-> ANALOG_POWER_ON)
    else $error("conversion started while off");
  a_conv_min: assert property ($fell(SAMPLE_HOLD) && ANALOG_POWER_ON |-> hold_cnt >= 12'd25)
    else $error("conversion shorter than 13 converter clocks");
  a_mux_held: assert property (SAMPLE_HOLD && $past(SAMPLE_HOLD) |-> $stable(CHANNEL_SELECT) && $stable(REFERENCE_SELECT))
    else $error("selection changed during conversion");
  a_irq_global: assert property (COMPLETION_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("interrupt without global enable");
  a_vector_clr: assert property (s_vec_idle |=> ##1 !COMPLETION_IRQ)
    else $error("interrupt stays after vector taken");
endmodule

bind adcctl_top adcctl_properties u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .REFERENCE_SELECT(REFERENCE_SELECT), .CHANNEL_SELECT(CHANNEL_SELECT),
  .ANALOG_POWER_ON(ANALOG_POWER_ON), .SAMPLE_HOLD(SAMPLE_HOLD), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .IRQ_VECTOR_TAKEN(IRQ_VECTOR_TAKEN), .COMPLETION_IRQ(COMPLETION_IRQ)
);

// ### tb_adc_control_result_regs.sv
`timescale 1ns/1ps
module tb_adc_control_result_regs;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, gie = 1'b0, vec = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] trig = 8'h00; // auto triggering left idle
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0, rv;
  logic [9:0] code = 10'h2a5;
  wire [31:0] rdata;
  wire [1:0] ref_sel;
  wire [4:0] ch_sel;
  wire wreq, pwr, sh, irq;
  int error_cnt = 0, check_count = 0, len;
  // 25 MHz core clock
  always #20 clk = ~clk;
  adcctl_top u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .REFERENCE_SELECT(ref_sel), .CHANNEL_SELECT(ch_sel), .ANALOG_POWER_ON(pwr), .SAMPLE_HOLD(sh),
    .CONVERSION_CODE(code), .TRIGGER_SOURCES(trig), .GLOBAL_IRQ_ENABLE(gie),
    .IRQ_VECTOR_TAKEN(vec), .COMPLETION_IRQ(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
    begin
      @(posedge clk);
    end
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // start a conversion and time how long it samples
  task automatic conv(input logic [7:0] ctl, input int cyc, input int div);
    bus(1'b1, 8'h7a, 4'h4, {8'h00, ctl, 16'h0000});
    len = 0;
    @(posedge clk);
    while (sh === 1'b1 && len < 5000)
    begin
      @(posedge clk);
      len++;
    end
    chk(32'(len >= cyc - div - 2 && len <= cyc + div + 2), 32'h1, "length");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h78, 4'hf, 32'h0);
    chk(rv, 32'h0, "result word at reset");
    bus(1'b0, 8'h7c, 4'h1, 32'h0);
    chk(rv, 32'h0, "select at reset");
    bus(1'b0, 8'h40, 4'hf, 32'h0);
    chk(rv, 32'h0, "unmapped read");
    $display("done: reset");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h7c, 4'h1, {24'h0, 2'(i), 1'b0, 5'(28 + i)});
      repeat (2) @(posedge clk);
      chk({25'h0, ref_sel, ch_sel}, {25'h0, 2'(i), 5'(28 + i)}, "select pins");
    end
    $display("done: select");
    conv(8'hc0, 50, 2);
    bus(1'b0, 8'h78, 4'h7, 32'h0);
    chk({8'h0, rv[23:0]}, 32'h009002a5, "first result");
    bus(1'b1, 8'h7a, 4'h4, 32'h00800000);
    bus(1'b0, 8'h78, 4'h4, 32'h0);
    chk({24'h0, rv[23:16]}, 32'h90, "flag kept");
    bus(1'b1, 8'h7a, 4'h4, 32'h00900000);
    bus(1'b0, 8'h78, 4'h4, 32'h0);
    chk({24'h0, rv[23:16]}, 32'h80, "flag cleared");
    code <= 10'h3ff;
    conv(8'hd3, 104, 8);
    bus(1'b0, 8'h78, 4'h3, 32'h0);
    chk({16'h0, rv[15:0]}, 32'h03ff, "right justified");
    bus(1'b1, 8'h7c, 4'h1, 32'h00000020);
    bus(1'b0, 8'h78, 4'h3, 32'h0);
    chk({16'h0, rv[15:0]}, 32'hffc0, "left justified");
    $display("done: conversions");
    bus(1'b0, 8'h78, 4'h1, 32'h0);
    code <= 10'h001;
    conv(8'hd1, 26, 2);
    bus(1'b0, 8'h78, 4'h2, 32'h0);
    chk({24'h0, rv[15:8]}, 32'hff, "locked high byte");
    $display("done: lock");
    bus(1'b1, 8'h7a, 4'h4, 32'h00880000);
    gie <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq after vector");
    $display("done: interrupt");
    // trigger source 1, auto on: one start per rising trigger
    bus(1'b1, 8'h7b, 4'h8, 32'h01000000);
    bus(1'b1, 8'h7a, 4'h4, 32'h00a00000);
    trig <= 8'h02;
    repeat (3) @(posedge clk);
    chk({31'h0, sh}, 32'h1, "triggered start");
    repeat (40) @(posedge clk);
    chk({31'h0, sh}, 32'h0, "one start per edge");
    bus(1'b1, 8'h7b, 4'h8, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, sh}, 32'h0, "no trigger on free select");
    bus(1'b1, 8'h7a, 4'h4, 32'h00f00000);
    repeat (40) @(posedge clk);
    chk({31'h0, sh}, 32'h1, "free running restart");
    bus(1'b0, 8'h78, 4'h4, 32'h0);
    chk({24'h0, rv[23:16]}, 32'hf0, "free running status");
    bus(1'b1, 8'h7a, 4'h4, 32'h00100000);
    $display("done: triggers");
    bus(1'b1, 8'h7a, 4'h4, 32'h00d00000);
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h7a, 4'h4, 32'h00000000);
    repeat (3) @(posedge clk);
    chk({30'h0, pwr, sh}, 32'h0, "abort pins");
    bus(1'b0, 8'h78, 4'h4, 32'h0);
    chk({24'h0, rv[23:16]}, 32'h00, "abort status");
    $display("done: abort");
    conclude();
  end
endmodule
